// >>> src/erc_pkg.sv
// Constants, carriers and state layout of the enclave re-entry check block.
// Assumes one 250 MHz core clock and an Avalon-MM register slave with waitrequest.
//
// Function
// - Leaf value 03H starts re-entry; second operand is structure, third is exit pointer.
// - Fault when the thread control structure address is misaligned.
// - That address must sit on a 4KByte boundary, else general-protection fault.
// - Fault when any must-be-zero flag bit of the structure is set.
// - Fault when the structure is invalid, unavailable or locked elsewhere.
// - Fault when the current 32/64-bit mode differs from the enclave mode attribute.
// - Fault when the enclave control structure is busy in another enclave.
// - In 32-bit mode, fault when proposed FS or GS is not inside the current DS segment.
// - Fault when any DS, ES, CS or SS base is nonzero.
// - Extended save present but not OS enabled: fault unless feature mask equals 3.
// - OS extended save enabled: fault when feature mask exceeds feature control.
// - Fault when bytes 520-535 of the saved extended area are nonzero.
// - Fault when the vector at byte 512 holds bits outside the feature mask.
// - Fault when the selected state save frame is invalid or busy.
// - General-protection fault when the current save frame index is zero.
// - In 64-bit mode, fault when the exit pointer is not canonical.
// - On success store the exit pointer into the thread control structure.
// - Save FS and GS; new bases from offsets, limits only in 32-bit mode.
// - With OS extended save, save feature control and load it with the mask.
// - Opt-out: save and clear trap flag, restore at exit; flag pops cannot set it.
// - Opt-in: pend a single-step exception right after the entry.
// - Suppress code breakpoints outside range; opt-out also suppresses overlapping ones.
// - Opt-out suppresses thread monitoring and sampling except fixed counters one, two.
// - Opt-out demotes other threads to own-thread counting, setting their bit 60.
// - Opt-out suppression sets bits 60 and 63 of global perf status.
package erc_pkg;

    // ======================================================================
    // Bus carrier
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } erc_av_s;

    // ======================================================================
    // Word indices; byte address is four times the index.
    localparam logic [5:0] W_LEAF  = 6'h00;
    localparam logic [5:0] W_TCS   = 6'h01;
    localparam logic [5:0] W_AEPL  = 6'h02;
    localparam logic [5:0] W_AEPH  = 6'h03;
    localparam logic [5:0] W_CPU   = 6'h04;
    localparam logic [5:0] W_FLAGS = 6'h05;
    localparam logic [5:0] W_TSTAT = 6'h06;
    localparam logic [5:0] W_CURRENT_SAVE_FRAME_INDEX  = 6'h07;
    localparam logic [5:0] W_FSOFS = 6'h08;
    localparam logic [5:0] W_GSOFS = 6'h09;
    localparam logic [5:0] W_FSLIM = 6'h0A;
    localparam logic [5:0] W_GSLIM = 6'h0B;
    localparam logic [5:0] W_SECSB = 6'h0C;
    localparam logic [5:0] W_DSLIM = 6'h0D;
    localparam logic [5:0] W_ENCLAVE_FEATURE_REQUEST_MASK  = 6'h0E;
    localparam logic [5:0] W_EXTENDED_FEATURE_CONTROL  = 6'h0F;
    localparam logic [5:0] W_XSHDR = 6'h10;
    localparam logic [5:0] R_SAEPL = 6'h11;
    localparam logic [5:0] R_SAEPH = 6'h12;
    localparam logic [5:0] R_FSB   = 6'h13;
    localparam logic [5:0] R_GSB   = 6'h14;
    localparam logic [5:0] R_FSL   = 6'h15;
    localparam logic [5:0] R_GSL   = 6'h16;
    localparam logic [5:0] R_SFSB  = 6'h17;
    localparam logic [5:0] R_SGSB  = 6'h18;
    localparam logic [5:0] R_SXCR0 = 6'h19;
    localparam logic [5:0] R_DBG   = 6'h1A;
    localparam logic [5:0] R_CTRL  = 6'h1B;
    localparam int         NWORD   = 27;
    localparam logic [5:0] NCFG    = 6'h11;

    // ======================================================================
    // Values and masks
    localparam logic [7:0]  LEAF_RESUME = 8'h03;
    localparam logic [11:0] PAGE_OFS    = 12'h000;
    localparam logic [31:0] FLAGS_MBZ   = 32'hFFFF_FFFE;
    localparam logic [31:0] ENCLAVE_FEATURE_REQUEST_MASK_LEGACY = 32'h0000_0003;
    localparam logic [31:0] DS_4GB      = 32'hFFFF_FFFF;
    localparam logic [31:0] CURRENT_SAVE_FRAME_INDEX_NONE   = 32'h0000_0000;

    // ======================================================================
    // Field positions
    localparam int CPU_M64 = 0;
    localparam int CPU_OSX = 1;
    localparam int CPU_FXS = 2;
    localparam int CPU_XAV = 3;
    localparam int CPU_TF  = 4;
    localparam int FL_OPTIN = 0;
    localparam int TS_VALID = 0;
    localparam int TS_AVAIL = 1;
    localparam int TS_LOCK  = 2;
    localparam int TS_SBUSY = 3;
    localparam int TS_SSAV  = 4;
    localparam int TS_SSAB  = 5;
    localparam int TS_SM64  = 6;
    localparam int TS_XRSV  = 7;
    localparam int TS_SEGB  = 8;
    localparam int DB_INENC = 0;
    localparam int DB_OPTO  = 1;
    localparam int DB_STF   = 2;
    localparam int DB_PSS   = 3;
    localparam int DB_PSUP  = 4;
    localparam int DB_G60   = 5;
    localparam int DB_G63   = 6;
    localparam int DB_BPOV  = 7;
    localparam int CT_EXIT  = 0;
    localparam int CT_POPF  = 1;
    localparam int CT_NTF   = 2;

    // ======================================================================
    // Fault checks in priority order and their class
    localparam int F_SEGB = 0;
    localparam int F_ALGN = 1;
    localparam int F_CANO = 2;
    localparam int F_LOCK = 3;
    localparam int F_TCSV = 4;
    localparam int F_MBZ  = 5;
    localparam int F_SBSY = 6;
    localparam int F_MODE = 7;
    localparam int F_FXSR = 8;
    localparam int F_ENCLAVE_FEATURE_REQUEST_MASK = 9;
    localparam int F_CURRENT_SAVE_FRAME_INDEX = 10;
    localparam int F_SSA  = 11;
    localparam int F_XHDR = 12;
    localparam int F_FSGS = 13;
    localparam int NF     = 14;
    localparam logic [13:0] PF_MASK = 14'h0810;

    typedef enum logic {ERC_IDLE, ERC_CHECK} erc_st_e;

    typedef struct packed {
        erc_st_e                st;
        logic                   ack;
        logic [31:0]            rdata;
        logic [NWORD-1:0][31:0] r;
        logic [3:0]             cause;
        logic                   lgp;
        logic                   lpf;
        logic                   done;
        logic                   demote;
    } erc_state_s;

endpackage

// >>> src/erc_core.sv
// Enclave re-entry check and state-change engine with its register file.
// Assumes the core fills the context words over the bus before writing the leaf word.
`timescale 1ns/1ns
module erc_core (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Register bus
    input  wire erc_pkg::erc_av_s  av,
    output logic [31:0]            readdata,
    output logic                   waitrequest,
    // Check outcome
    output logic                   done,
    output logic                   fault_gp,
    output logic                   fault_pf,
    // Debug and monitoring control
    output logic                   in_enclave,
    output logic                   bp_sup_overlap,
    output logic                   perf_sup,
    output logic                   demote_other,
    output logic                   single_step_pend
);
    import erc_pkg::*;

    // ======================================================================
    // State
    erc_state_s  s_q;
    erc_state_s  s_d;
    logic [5:0]  idx;
    logic        req;
    logic [31:0] cpu;
    logic [31:0] ts;
    logic [31:0] dbg;
    logic [31:0] aeph;
    logic [31:0] fsb;
    logic [31:0] gsb;
    logic [31:0] fsl;
    logic [31:0] gsl;
    logic        m64;
    logic        optout;
    logic [NF-1:0] fv;
    logic        commit;

    assign idx    = av.address[7:2];
    assign req    = av.read | av.write;
    assign cpu    = s_q.r[W_CPU];
    assign ts     = s_q.r[W_TSTAT];
    assign dbg    = s_q.r[R_DBG];
    assign aeph   = s_q.r[W_AEPH];
    assign m64    = cpu[CPU_M64];
    assign optout = ~s_q.r[W_FLAGS][FL_OPTIN];
    assign fsb    = s_q.r[W_FSOFS] + s_q.r[W_SECSB];
    assign gsb    = s_q.r[W_GSOFS] + s_q.r[W_SECSB];
    assign fsl    = fsb + s_q.r[W_FSLIM];
    assign gsl    = gsb + s_q.r[W_GSLIM];

    // A wrapped segment is only legal when DS has no hole, i.e. spans all 4GB.
    function automatic logic outside_ds(input logic [31:0] b, input logic [31:0] l,
                                        input logic [31:0] ds);
        outside_ds = (l < b) ? (ds != DS_4GB) : (l > ds);
    endfunction

    // ======================================================================
    // Checks
    always_comb
    begin
        fv         = '0;
        fv[F_SEGB] = |ts[TS_SEGB+3:TS_SEGB];
        fv[F_ALGN] = s_q.r[W_TCS][11:0] != PAGE_OFS;
        fv[F_CANO] = m64 & ~((&aeph[31:15]) | ~(|aeph[31:15]));
        fv[F_LOCK] = ts[TS_LOCK];
        fv[F_TCSV] = ~ts[TS_VALID] | ~ts[TS_AVAIL];
        fv[F_MBZ]  = |(s_q.r[W_FLAGS] & FLAGS_MBZ);
        fv[F_SBSY] = ts[TS_SBUSY];
        fv[F_MODE] = m64 != ts[TS_SM64];
        fv[F_FXSR] = ~cpu[CPU_FXS];
        fv[F_ENCLAVE_FEATURE_REQUEST_MASK] = cpu[CPU_OSX]
                   ? |(s_q.r[W_ENCLAVE_FEATURE_REQUEST_MASK] & ~s_q.r[W_EXTENDED_FEATURE_CONTROL])
                   : cpu[CPU_XAV] & (s_q.r[W_ENCLAVE_FEATURE_REQUEST_MASK] != ENCLAVE_FEATURE_REQUEST_MASK_LEGACY);
        fv[F_CURRENT_SAVE_FRAME_INDEX] = s_q.r[W_CURRENT_SAVE_FRAME_INDEX] == CURRENT_SAVE_FRAME_INDEX_NONE;
        fv[F_SSA]  = ~ts[TS_SSAV] | ts[TS_SSAB];
        fv[F_XHDR] = ts[TS_XRSV] | |(s_q.r[W_XSHDR] & ~s_q.r[W_ENCLAVE_FEATURE_REQUEST_MASK]);
        fv[F_FSGS] = ~m64 & (outside_ds(fsb, fsl, s_q.r[W_DSLIM])
                           | outside_ds(gsb, gsl, s_q.r[W_DSLIM]));
    end

    assign commit = (s_q.st == ERC_CHECK) && (fv == '0);

    // ======================================================================
    // Next state
    always_comb
    begin
        s_d        = s_q;
        s_d.done   = 1'b0;
        s_d.demote = 1'b0;
        s_d.ack    = 1'b0;
        // Each access is held one cycle, or two when it arrives during a check, so read data always comes from a flop.
        if (s_q.st == ERC_IDLE && req && !s_q.ack)
        begin
            s_d.ack   = 1'b1;
            s_d.rdata = 32'h0000_0000;
            if (idx == W_LEAF)
            begin
                s_d.rdata = {24'h00_0000, s_q.cause, s_q.lpf, s_q.lgp, 1'b0, 1'b0};
            end
            else if (idx < R_CTRL)
            begin
                s_d.rdata = s_q.r[idx];
            end
        end
        if (s_q.ack && av.write)
        begin
            if (idx < NCFG)
            begin
                s_d.r[idx] = av.writedata;
            end
            if (idx == W_LEAF && av.writedata[7:0] == LEAF_RESUME)
            begin
                s_d.st = ERC_CHECK;
            end
            if (idx == R_DBG)
            begin
                s_d.r[R_DBG][DB_PSS] = dbg[DB_PSS] & ~av.writedata[DB_PSS];
                s_d.r[R_DBG][DB_G60] = dbg[DB_G60] & ~av.writedata[DB_G60];
                s_d.r[R_DBG][DB_G63] = dbg[DB_G63] & ~av.writedata[DB_G63];
            end
            if (idx == R_CTRL && av.writedata[CT_POPF])
            begin
                // Inside an opt-out enclave a flag pop can never raise the trap flag.
                s_d.r[W_CPU][CPU_TF] = av.writedata[CT_NTF]
                                     & ~(dbg[DB_INENC] & dbg[DB_OPTO]);
            end
            if (idx == R_CTRL && av.writedata[CT_EXIT] && dbg[DB_INENC])
            begin
                if (dbg[DB_OPTO])
                begin
                    s_d.r[W_CPU][CPU_TF] = dbg[DB_STF];
                end
                s_d.r[R_DBG][DB_INENC] = 1'b0;
                s_d.r[R_DBG][DB_OPTO]  = 1'b0;
                s_d.r[R_DBG][DB_PSUP]  = 1'b0;
                s_d.r[R_DBG][DB_BPOV]  = 1'b0;
            end
        end
        if (s_q.st == ERC_CHECK)
        begin
            s_d.st    = ERC_IDLE;
            s_d.done  = 1'b1;
            s_d.lgp   = 1'b0;
            s_d.lpf   = 1'b0;
            s_d.cause = 4'h0;
            // The lowest set check wins, so only the first fault is reported.
            for (int i = NF - 1; i >= 0; i--)
            begin
                if (fv[i])
                begin
                    s_d.cause = 4'(i);
                    s_d.lgp   = ~PF_MASK[i];
                    s_d.lpf   = PF_MASK[i];
                end
            end
            if (commit)
            begin
                s_d.r[R_SAEPL] = s_q.r[W_AEPL];
                s_d.r[R_SAEPH] = s_q.r[W_AEPH];
                s_d.r[R_SFSB]  = s_q.r[R_FSB];
                s_d.r[R_SGSB]  = s_q.r[R_GSB];
                s_d.r[R_FSB]   = fsb;
                s_d.r[R_GSB]   = gsb;
                if (!m64)
                begin
                    s_d.r[R_FSL] = fsl;
                    s_d.r[R_GSL] = gsl;
                end
                if (cpu[CPU_OSX])
                begin
                    s_d.r[R_SXCR0] = s_q.r[W_EXTENDED_FEATURE_CONTROL];
                    s_d.r[W_EXTENDED_FEATURE_CONTROL]  = s_q.r[W_ENCLAVE_FEATURE_REQUEST_MASK];
                end
                s_d.r[R_DBG][DB_INENC] = 1'b1;
                s_d.r[R_DBG][DB_OPTO]  = optout;
                // Stale suppression from an earlier entry must not leak into an opt-in one.
                s_d.r[R_DBG][DB_BPOV]  = optout;
                s_d.r[R_DBG][DB_PSUP]  = optout;
                if (optout)
                begin
                    s_d.r[R_DBG][DB_STF]  = cpu[CPU_TF];
                    s_d.r[W_CPU][CPU_TF]  = 1'b0;
                    s_d.r[R_DBG][DB_G60]  = 1'b1;
                    s_d.r[R_DBG][DB_G63]  = 1'b1;
                    s_d.demote            = 1'b1;
                end
                else
                begin
                    s_d.r[R_DBG][DB_PSS] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // Outputs
    assign waitrequest      = req & ~s_q.ack;
    assign readdata         = s_q.rdata;
    assign done             = s_q.done;
    assign fault_gp         = s_q.done & s_q.lgp;
    assign fault_pf         = s_q.done & s_q.lpf;
    assign in_enclave       = dbg[DB_INENC];
    assign bp_sup_overlap   = dbg[DB_BPOV];
    assign perf_sup         = dbg[DB_PSUP];
    assign demote_other     = s_q.demote;
    assign single_step_pend = dbg[DB_PSS];

    // ======================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_leaf_start: assert property (s_q.ack && av.write && idx == W_LEAF
        && av.writedata[7:0] == LEAF_RESUME |=> s_q.st == ERC_CHECK ##1 done)
        else $error("resume leaf did not start a check");
    a_align_gp: assert property (s_q.st == ERC_CHECK && fv[F_ALGN]
        |=> fault_gp && !fault_pf)
        else $error("misaligned structure gave no protection fault");
    a_abort_keep: assert property (s_q.st == ERC_CHECK && fv != '0
        |=> $stable(s_q.r[R_SAEPL]) && $stable(s_q.r[W_EXTENDED_FEATURE_CONTROL]) && $stable(s_q.r[R_FSB]))
        else $error("failed check changed state");
    a_aep_store: assert property (commit
        |=> s_q.r[R_SAEPL] == $past(s_q.r[W_AEPL]) && !fault_gp && !fault_pf)
        else $error("exit pointer not stored");
    a_mask_load: assert property (commit && cpu[CPU_OSX]
        |=> s_q.r[W_EXTENDED_FEATURE_CONTROL] == $past(s_q.r[W_ENCLAVE_FEATURE_REQUEST_MASK]) && s_q.r[R_SXCR0] == $past(s_q.r[W_EXTENDED_FEATURE_CONTROL]))
        else $error("feature control not swapped");
    a_trap_clear: assert property (commit && optout
        |=> !s_q.r[W_CPU][CPU_TF] && demote_other ##1 !demote_other)
        else $error("opt-out entry left trap flag set");
    a_popf_block: assert property (s_q.ack && av.write && idx == R_CTRL
        && av.writedata[CT_POPF] && in_enclave && dbg[DB_OPTO] |=> !s_q.r[W_CPU][CPU_TF])
        else $error("flag pop set trap flag in enclave");
    a_optin_pend: assert property (commit && !optout
        |=> single_step_pend && !perf_sup)
        else $error("opt-in entry pended no single step");
    a_perf_stat: assert property (commit && optout
        |=> dbg[DB_G60] && dbg[DB_G63] && perf_sup && bp_sup_overlap)
        else $error("global perf status bits not set");
    a_current_save_frame_index_zero: assert property (s_q.st == ERC_CHECK && fv[F_CURRENT_SAVE_FRAME_INDEX]
        && !fv[F_TCSV] |=> done && fault_gp && !fault_pf && $stable(in_enclave))
        else $error("zero frame index not faulted");
    a_segb_gp: assert property (s_q.st == ERC_CHECK && fv[F_SEGB]
        |=> fault_gp && !fault_pf && s_q.cause == 4'h0)
        else $error("nonzero segment base not faulted first");
    a_ssa_pf: assert property (s_q.st == ERC_CHECK && fv[F_SSA]
        && fv[F_SSA-1:0] == '0 |=> fault_pf && !fault_gp && $stable(in_enclave))
        else $error("busy or invalid frame gave no page fault");
    a_fsgs_gp: assert property (s_q.st == ERC_CHECK && fv[F_FSGS]
        && fv[F_FSGS-1:0] == '0 |=> fault_gp && !fault_pf && $stable(s_q.r[R_FSB]))
        else $error("segment outside DS not faulted");
    a_optin_clean: assert property (commit && !optout
        |=> !bp_sup_overlap && !demote_other)
        else $error("opt-in entry kept opt-out suppression");
    a_bus_answer: assert property (req && !waitrequest |=> !s_q.ack)
        else $error("bus answer held more than one cycle");

    c_commit_out: cover property (commit && optout);
    c_commit_in:  cover property (commit && !optout);
    c_fault_pf:   cover property (fault_pf);
    c_exit_tf:    cover property (s_q.ack && av.write && idx == R_CTRL && in_enclave);

endmodule

// >>> tb/erc_core_test.sv
// Self-checking bench for the enclave re-entry check engine.
// Assumes erc_pkg and erc_core are compiled first; the bench is the only bus master.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module erc_core_test;
    import erc_pkg::*;
    logic              clk;
    logic              nrst;
    erc_av_s           av;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic              done;
    logic              fault_gp;
    logic              fault_pf;
    logic              in_enclave;
    logic              bp_sup_overlap;
    logic              perf_sup;
    logic              demote_other;
    logic              single_step_pend;
    int                n_mismatch;
    int                samples_checked;
    int                n_done;
    int                n_demote;
    logic              gp_seen;
    logic              pf_seen;
    logic [31:0]       rd;
    logic [31:0]       res;
    int                k;

    erc_core u_dut (.clk(clk), .nrst(nrst), .av(av), .readdata(readdata),
        .waitrequest(waitrequest), .done(done), .fault_gp(fault_gp), .fault_pf(fault_pf),
        .in_enclave(in_enclave), .bp_sup_overlap(bp_sup_overlap), .perf_sup(perf_sup),
        .demote_other(demote_other), .single_step_pend(single_step_pend));

    // ======================================================================
    // Clock, outcome watcher and watchdog
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Pulses are counted here so no task can miss a one-cycle event.
    always @(posedge clk)
    begin
        if (done)
        begin
            n_done  <= n_done + 1;
            gp_seen <= fault_gp;
            pf_seen <= fault_pf;
        end
        if (demote_other)
            n_demote <= n_demote + 1;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out;
    end

    // ======================================================================
    // Bus access; the request stands until the edge where waitrequest is low.
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        av <= '{address: a, read: !wr, write: wr, writedata: d};
        do
            @(posedge clk);
        while (waitrequest);
        rd = readdata;
        av <= '0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] ex);
        bus(a, 1'b0, 32'h0000_0000);
        `CHK("register read", ex, rd)
    endtask

    // Legal context; words 0x04 to 0x40 in address order.
    task automatic setup(input logic m64, input logic optin);
        logic [31:0] v [1:16];
        v = '{32'h0001_0000, 32'h0000_1000, 32'h0000_0000, {27'h0, 4'hF, m64},
              {31'h0, optin}, {25'h0, m64, 6'h13}, 32'h0000_0001, 32'h0000_1000,
              32'h0000_2000, 32'h0000_0FFF, 32'h0000_0FFF, 32'h0010_0000,
              32'hFFFF_FFFF, 32'h0000_0003, 32'h0000_0007, 32'h0000_0003};
        for (int i = 1; i <= 16; i++)
            bus(8'(4 * i), 1'b1, v[i]);
    endtask

    task automatic run(output logic [31:0] r);
        int t0;
        int w;
        t0 = n_done;
        bus(8'h00, 1'b1, 32'h0000_0003);
        w = 0;
        while (n_done == t0 && w < 20)
        begin
            @(negedge clk);
            w++;
        end
        repeat (3) @(posedge clk);
        `CHK("done count", t0 + 1, n_done)
        bus(8'h00, 1'b0, 32'h0000_0000);
        r = rd;
    endtask

    task automatic fault_case(input logic m64, input logic [7:0] a, input logic [31:0] v,
        input logic [3:0] cause, input logic pf,
        input logic [7:0] a2 = 8'h40, input logic [31:0] v2 = 32'h0000_0003);
        logic [31:0] r;
        setup(m64, 1'b0);
        bus(a, 1'b1, v);
        bus(a2, 1'b1, v2);
        run(r);
        `CHK("fault cause", {24'h0, cause, pf, !pf, 2'b00}, r)
        `CHK("fault pulses", {!pf, pf}, {gp_seen, pf_seen})
    endtask

    task automatic close_out;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        nrst = 1'b0;
        av = '0;
        n_mismatch = 0;
        samples_checked = 0;
        n_done = 0;
        n_demote = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        `CHK("reset ports", 5'h00, {in_enclave, bp_sup_overlap, perf_sup, single_step_pend,
            demote_other})
        rchk(8'h68, 32'h0000_0000);
        setup(1'b1, 1'b0);
        k = n_done;
        bus(8'h00, 1'b1, 32'h0000_0002);
        repeat (6) @(posedge clk);
        `CHK("other leaf ignored", k, n_done)
        fault_case(1'b1, 8'h18, 32'h0000_0153, 4'd0, 1'b0);
        fault_case(1'b1, 8'h04, 32'h0001_0800, 4'd1, 1'b0);
        fault_case(1'b1, 8'h0C, 32'h0001_0000, 4'd2, 1'b0);
        fault_case(1'b1, 8'h18, 32'h0000_0057, 4'd3, 1'b0);
        fault_case(1'b1, 8'h18, 32'h0000_0052, 4'd4, 1'b1);
        fault_case(1'b1, 8'h14, 32'h0000_0002, 4'd5, 1'b0);
        fault_case(1'b1, 8'h18, 32'h0000_005B, 4'd6, 1'b0);
        fault_case(1'b1, 8'h18, 32'h0000_0013, 4'd7, 1'b0);
        fault_case(1'b1, 8'h10, 32'h0000_001B, 4'd8, 1'b0);
        fault_case(1'b1, 8'h10, 32'h0000_001D, 4'd9, 1'b0, 8'h38, 32'h0000_0007);
        fault_case(1'b1, 8'h38, 32'h0000_000F, 4'd9, 1'b0);
        fault_case(1'b1, 8'h1C, 32'h0000_0000, 4'd10, 1'b0);
        fault_case(1'b1, 8'h18, 32'h0000_0043, 4'd11, 1'b1);
        fault_case(1'b1, 8'h18, 32'h0000_0073, 4'd11, 1'b1);
        fault_case(1'b1, 8'h18, 32'h0000_00D3, 4'd12, 1'b0);
        fault_case(1'b1, 8'h40, 32'h0000_0007, 4'd12, 1'b0, 8'h38, 32'h0000_0003);
        fault_case(0, 8'h34, 32'h0010_0000, 4'd13, 1'b0);
        fault_case(1'b1, 8'h04, 32'h0001_0800, 4'd1, 1'b0, 8'h1C, 32'h0000_0000);
        rchk(8'h44, 32'h0000_0000);
        rchk(8'h3C, 32'h0000_0007);
        rchk(8'h68, 32'h0000_0000);
        // Opt-out entry in 64-bit mode with the trap flag set beforehand.
        setup(1'b1, 1'b0);
        k = n_demote;
        run(res);
        `CHK("success code", 32'h0000_0000, res)
        rchk(8'h44, 32'h0000_1000);
        rchk(8'h48, 32'h0000_0000);
        rchk(8'h4C, 32'h0010_1000);
        rchk(8'h50, 32'h0010_2000);
        rchk(8'h5C, 32'h0000_0000);
        rchk(8'h64, 32'h0000_0007);
        rchk(8'h3C, 32'h0000_0003);
        rchk(8'h68, 32'h0000_00F7);
        rchk(8'h10, 32'h0000_000F);
        `CHK("opt-out ports", 4'hE, {in_enclave, bp_sup_overlap, perf_sup,
            single_step_pend})
        `CHK("demote pulse", k + 1, n_demote)
        bus(8'h6C, 1'b1, 32'h0000_0006);
        rchk(8'h10, 32'h0000_000F);
        bus(8'h6C, 1'b1, 32'h0000_0001);
        rchk(8'h10, 32'h0000_001F);
        `CHK("exit ports", 3'h0, {in_enclave, bp_sup_overlap, perf_sup})
        // Opt-in entry in 32-bit mode; the upper pointer word is not checked there.
        setup(1'b0, 1'b1);
        bus(8'h0C, 1'b1, 32'h0001_0000);
        k = n_demote;
        run(res);
        `CHK("success code", 32'h0000_0000, res)
        `CHK("opt-in ports", 4'h9, {in_enclave, bp_sup_overlap, perf_sup,
            single_step_pend})
        `CHK("no demote", k, n_demote)
        rchk(8'h5C, 32'h0010_1000);
        bus(8'h68, 1'b1, 32'h0000_0008);
        @(negedge clk);
        `CHK("pend cleared", 1'b0, single_step_pend)
        bus(8'h44, 1'b1, 32'hFFFF_FFFF);
        rchk(8'h44, 32'h0000_1000);
        rchk(8'h70, 32'h0000_0000);
        bus(8'h6C, 1'b1, 32'h0000_0001);
        close_out;
    end
endmodule
